/* File: src/ismo_consts.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef ISMO_CONSTS_SVH
`define ISMO_CONSTS_SVH
// Demultiplexed offsets
`define ISMO_DMX_STATUS_OFS  6'h0E
`define ISMO_DMX_MODE_OFS    6'h0F
// Multiplexed offsets
`define ISMO_MUX_STATUS_OFS  6'h1C
`define ISMO_MUX_MODE_OFS_A  6'h1E
`define ISMO_MUX_MODE_OFS_B  6'h3E
// Status and mask field positions
`define ISMO_BIT_TIMER       7
`define ISMO_BIT_SFIFO       6
`define ISMO_BIT_MONDONE     5
`define ISMO_BIT_MONACT      4
`define ISMO_BIT_FSYNC       3
`define ISMO_BIT_MISMATCH    2
`define ISMO_BIT_SWIN        1
`define ISMO_BIT_SOVR        0
// Mode register fields
`define ISMO_MODE_HI         7
`define ISMO_MODE_LO         6
`define ISMO_BANK_BIT        0
// Reset values
`define ISMO_STATUS_RST      8'h00
`define ISMO_MASK_RST        8'h00
`define ISMO_MODE_RST        8'h00
// Access times in half reference clock periods
`define ISMO_HALF_CLR        16'h0200
`define ISMO_HALF_INIT       16'h0005
`define ISMO_HALF_NORM       16'h0013
`define ISMO_HALF_TRI        16'h0816
`define ISMO_HALF_TEST       16'h1012
`endif

/* File: src/ismo_pkg.sv */
// Types shared by the interrupt and mode block
package ismo_pkg;
  typedef enum logic [1:0] {
    ISMO_MODE_CLR  = 2'b00,
    ISMO_MODE_TEST = 2'b01,
    ISMO_MODE_INIT = 2'b10,
    ISMO_MODE_NORM = 2'b11
  } ismo_mode_t;

  typedef enum logic [0:0] {
    ISMO_MEM_IDLE = 1'b0,
    ISMO_MEM_BUSY = 1'b1
  } ismo_mem_st_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } ismo_bus_t;
endpackage

/* File: src/ismo_top.sv */
// Interrupt status, mask and operation mode block
`timescale 1ns/1ps
`include "ismo_consts.svh"
// What this block does
// R1: Timer expiry sets flag; status read clears
// R2: FIFO flag follows nonempty; read never clears
// R3: Monitor command done sets flag; read clears
// R4: Search hit sets flag; rearm by command
// R5: Frame sync toggle sets flag; read clears
// R6: Mismatch sets flag; rearm after compare read
// R7: Window opening sets flag when channel enabled
// R8: Missed window access sets overrun flag
// R9: Mask bit one suppresses matching source
// R10: Masked events held, shown when unmasked
// R11: Masked FIFO flag visible, no interrupt
// R12: Mask write briefly drops interrupt output
// R13: Mode bits 7:6 select operating mode
// R14: Mode 00 clears memory in 256 cycles
// R15: Mode 10 access within 2.5 cycles
// R16: Mode 11 access 9.5, tristate 1035
// R17: Mode 01 access all locations, 2057
// R18: Host should clear memory after reset
// R19: Host reads status after each interrupt
// R20: Multiplexed offsets 1C, 1E and 3E
// R21: Sync state needs sync and mode bit
// R22: Interrupt when any unmasked flag set
module ismo_top #(
  parameter int HALF_DIV    = 1,
  parameter int TEST_HALVES = `ISMO_HALF_TEST,
  parameter int TRI_HALVES  = `ISMO_HALF_TRI
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  // Register port
  input  wire logic              mux_mode_i,
  input  wire ismo_pkg::ismo_bus_t bus_i,
  output logic [7:0]             rdata_o,
  output logic                   rdata_oe_o,
  // Event sources
  input  wire logic              timer_start_i,
  input  wire logic              timer_gen_i,
  input  wire logic              timer_stop_i,
  input  wire logic              timer_expire_i,
  input  wire logic              sfifo_nonempty_i,
  input  wire logic              mon_done_i,
  input  wire logic              mon_search_cmd_i,
  input  wire logic              mon_found_i,
  input  wire logic              pcm_synced_i,
  input  wire logic              mismatch_i,
  input  wire logic              compare_read_i,
  input  wire logic              chan_a_enable_i,
  input  wire logic              chan_b_enable_i,
  input  wire logic              swin_open_i,
  input  wire logic              swin_close_i,
  input  wire logic              sync_data_access_i,
  // Memory access
  input  wire logic              mem_req_i,
  input  wire logic              mem_tri_init_i,
  output logic                   mem_busy_o,
  output logic                   mem_done_o,
  output logic                   mem_all_loc_o,
  // Status outputs
  output logic                   irq_o,
  output logic                   iface_enable_o,
  output logic                   frame_sync_state_o,
  output logic                   mon_searching_o
);
  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic [7:0] mask_q;
  logic [7:0] mode_q;
  logic [7:0] pend_q;
  logic [7:0] set_d;
  logic [7:0] vis_d;
  logic       st_hit;
  logic       md_hit;
  logic       st_rd;
  logic       mask_wr;

  always_comb
  begin
    if (mux_mode_i)
    begin
      st_hit = bus_i.addr == `ISMO_MUX_STATUS_OFS; // R20
      md_hit = bus_i.addr == `ISMO_MUX_MODE_OFS_A ||
               bus_i.addr == `ISMO_MUX_MODE_OFS_B; // R20
    end
    else
    begin
      st_hit = bus_i.addr == `ISMO_DMX_STATUS_OFS && !mode_q[`ISMO_BANK_BIT];
      md_hit = bus_i.addr == `ISMO_DMX_MODE_OFS;
    end
  end

  assign st_rd   = bus_i.rd && st_hit;
  assign mask_wr = bus_i.wr && st_hit;

  // Visible status: masked latches hidden, FIFO level always shown
  always_comb
  begin
    vis_d                = pend_q & ~mask_q; // R10
    vis_d[`ISMO_BIT_SFIFO] = sfifo_nonempty_i; // R2 R11
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      rdata_o <= 8'h00;
    else if (bus_i.rd && st_hit)
      rdata_o <= vis_d;
    else if (bus_i.rd && md_hit)
      rdata_o <= mode_q;
    else if (bus_i.rd)
      rdata_o <= 8'h00;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      rdata_oe_o <= 1'b0;
    else
      rdata_oe_o <= bus_i.rd;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      mask_q <= `ISMO_MASK_RST;
    else if (mask_wr)
      mask_q <= bus_i.wdata; // R9
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      mode_q <= `ISMO_MODE_RST;
    else if (bus_i.wr && md_hit)
      mode_q <= bus_i.wdata; // R13
  end

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  logic timer_arm_q;
  logic mis_arm_q;
  logic swin_q;
  logic acc_q;
  logic pss_d;
  logic sync_en;

  assign pss_d   = pcm_synced_i && mode_q[`ISMO_MODE_LO]; // R21
  assign sync_en = chan_a_enable_i || chan_b_enable_i;

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      timer_arm_q <= 1'b0;
    else if (timer_start_i)
      timer_arm_q <= timer_gen_i; // R1
    else if (timer_stop_i)
      timer_arm_q <= 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      mon_searching_o <= 1'b0;
    else if (!mode_q[`ISMO_MODE_LO])
      mon_searching_o <= 1'b0;
    else if (mon_search_cmd_i)
      mon_searching_o <= 1'b1; // R4
    else if (mon_found_i)
      mon_searching_o <= 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      frame_sync_state_o <= 1'b0;
    else
      frame_sync_state_o <= pss_d; // R21
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      mis_arm_q <= 1'b1;
    else if (mismatch_i && mis_arm_q)
      mis_arm_q <= 1'b0;
    else if (compare_read_i)
      mis_arm_q <= 1'b1; // R6
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      swin_q <= 1'b0;
    else if (swin_open_i && sync_en)
      swin_q <= 1'b1;
    else if (swin_close_i)
      swin_q <= 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      acc_q <= 1'b0;
    else if (swin_open_i)
      acc_q <= 1'b0;
    else if (swin_q && sync_data_access_i)
      acc_q <= 1'b1;
  end

  always_comb
  begin
    set_d                     = 8'h00;
    set_d[`ISMO_BIT_TIMER]    = timer_expire_i && timer_arm_q; // R1
    set_d[`ISMO_BIT_MONDONE]  = mon_done_i; // R3
    set_d[`ISMO_BIT_MONACT]   = mon_found_i && mon_searching_o; // R4
    set_d[`ISMO_BIT_FSYNC]    = pss_d != frame_sync_state_o; // R5
    set_d[`ISMO_BIT_MISMATCH] = mismatch_i && mis_arm_q; // R6
    set_d[`ISMO_BIT_SWIN]     = swin_open_i && sync_en; // R7
    set_d[`ISMO_BIT_SOVR]     = swin_close_i && swin_q && !acc_q &&
                                !sync_data_access_i; // R8
  end

  // Set wins over read clear; only shown bits are cleared
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      pend_q <= `ISMO_STATUS_RST;
    else if (st_rd)
      pend_q <= (pend_q & mask_q) | set_d; // R10
    else
      pend_q <= pend_q | set_d;
  end

  // Masked FIFO flag kept off the line
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      irq_o <= 1'b0;
    else if (mask_wr)
      irq_o <= 1'b0; // R12
    else
      irq_o <= |(pend_q & ~mask_q) ||
               (sfifo_nonempty_i && !mask_q[`ISMO_BIT_SFIFO]); // R22 R11
  end

  // ----------------------------------------
  // Memory access timing
  // ----------------------------------------
  ismo_pkg::ismo_mode_t  mode_sel;
  ismo_pkg::ismo_mem_st_t mem_st_q;
  logic [15:0] div_q;
  logic        half_en;
  logic [15:0] cnt_q;
  logic [15:0] load_d;

  assign mode_sel = ismo_pkg::ismo_mode_t'(mode_q[`ISMO_MODE_HI:`ISMO_MODE_LO]); // R13
  assign half_en  = div_q == 16'(HALF_DIV - 1);

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i || half_en)
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end

  always_comb
  begin
    case (mode_sel)
      ismo_pkg::ISMO_MODE_CLR:  load_d = `ISMO_HALF_CLR; // R14
      ismo_pkg::ISMO_MODE_INIT: load_d = `ISMO_HALF_INIT; // R15
      ismo_pkg::ISMO_MODE_NORM: load_d = mem_tri_init_i ? 16'(TRI_HALVES)
                                                        : `ISMO_HALF_NORM; // R16
      ismo_pkg::ISMO_MODE_TEST: load_d = 16'(TEST_HALVES); // R17
      default:                  load_d = `ISMO_HALF_NORM;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      mem_st_q   <= ismo_pkg::ISMO_MEM_IDLE;
      cnt_q      <= 16'h0000;
      mem_done_o <= 1'b0;
    end
    else
    begin
      mem_done_o <= 1'b0;
      case (mem_st_q)
        ismo_pkg::ISMO_MEM_IDLE:
          if (mem_req_i)
          begin
            mem_st_q <= ismo_pkg::ISMO_MEM_BUSY;
            cnt_q    <= load_d;
          end
        ismo_pkg::ISMO_MEM_BUSY:
          if (half_en && cnt_q == 16'h0001)
          begin
            mem_st_q   <= ismo_pkg::ISMO_MEM_IDLE;
            cnt_q      <= 16'h0000;
            mem_done_o <= 1'b1;
          end
          else if (half_en)
            cnt_q <= cnt_q - 16'h0001;
        default:
          mem_st_q <= ismo_pkg::ISMO_MEM_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      mem_busy_o <= 1'b0;
    else if (mem_st_q == ismo_pkg::ISMO_MEM_IDLE)
      mem_busy_o <= mem_req_i;
    else
      mem_busy_o <= !(half_en && cnt_q == 16'h0001);
  end

  // Interfaces run in normal and test modes only
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      iface_enable_o <= 1'b0;
      mem_all_loc_o  <= 1'b0;
    end
    else
    begin
      iface_enable_o <= mode_q[`ISMO_MODE_LO]; // R14 R15 R16
      mem_all_loc_o  <= mode_sel == ismo_pkg::ISMO_MODE_TEST ||
                        mode_sel == ismo_pkg::ISMO_MODE_CLR; // R17
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_mask_write;
    mask_wr;
  endsequence
  sequence s_irq_low;
    !irq_o;
  endsequence

  property p_timer_set;
    set_d[`ISMO_BIT_TIMER] |=> pend_q[`ISMO_BIT_TIMER];
  endproperty
  a_timer_set: assert property (p_timer_set) else $error("timer flag lost"); // R1

  property p_sfifo_vis;
    bus_i.rd && st_hit |=> rdata_o[`ISMO_BIT_SFIFO] == $past(sfifo_nonempty_i);
  endproperty
  a_sfifo_vis: assert property (p_sfifo_vis) else $error("fifo flag wrong"); // R2

  property p_read_clear;
    st_rd && !set_d[`ISMO_BIT_MONDONE] && !mask_q[`ISMO_BIT_MONDONE]
      |=> !pend_q[`ISMO_BIT_MONDONE];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read no clear"); // R3

  property p_mis_rearm;
    set_d[`ISMO_BIT_MISMATCH] |=> !mis_arm_q;
  endproperty
  a_mis_rearm: assert property (p_mis_rearm) else $error("mismatch rearm"); // R6

  property p_swin_gate;
    swin_open_i && !sync_en && !pend_q[`ISMO_BIT_SWIN] |=> !pend_q[`ISMO_BIT_SWIN];
  endproperty
  a_swin_gate: assert property (p_swin_gate) else $error("window ungated"); // R7

  property p_mask_hold;
    st_rd && mask_q[`ISMO_BIT_TIMER] && pend_q[`ISMO_BIT_TIMER]
      |=> pend_q[`ISMO_BIT_TIMER];
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("masked lost"); // R10

  property p_mask_drop;
    s_mask_write |=> s_irq_low;
  endproperty
  a_mask_drop: assert property (p_mask_drop) else $error("no irq drop"); // R12

  property p_irq_cause;
    !mask_wr && (|(pend_q & ~mask_q)) |=> irq_o;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq missing"); // R22

  property p_init_time;
    mem_req_i && !mem_busy_o && mode_sel == ismo_pkg::ISMO_MODE_INIT && HALF_DIV == 1
      |=> mem_busy_o [*5] ##1 !mem_busy_o;
  endproperty
  a_init_time: assert property (p_init_time) else $error("init time"); // R15
endmodule // ismo_top

/* File: dv/ismo_host_model.sv */
// Host register bus model for the interrupt and mode block
`timescale 1ns/1ps
module ismo_host_model (
  // Clock
  input  wire logic          core_clk_i,
  // Register port
  output ismo_pkg::ismo_bus_t bus_o,
  input  wire logic [7:0]    rdata_i,
  input  wire logic          rdata_oe_i
);
  initial bus_o = '0;

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // One strobe edge, then released lines scrambled
  task automatic access(input logic r, input logic [5:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    bus_o = {r, ~r, a, d};
    @(negedge core_clk_i);
    bus_o = {2'b00, ~a, ~d};
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    access(1'b0, a, d);
  endtask

  // Data and drive enable taken while both stand, then lines released
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic oe);
    @(negedge core_clk_i);
    bus_o = {1'b1, 1'b0, a, 8'h00};
    @(negedge core_clk_i);
    d = rdata_i;
    oe = rdata_oe_i;
    bus_o = {2'b00, ~a, 8'hFF};
  endtask
endmodule // ismo_host_model

/* File: dv/tb_top.sv */
// Self-checking bench for the interrupt and mode block
`timescale 1ns/1ps
`include "ismo_consts.svh"
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module tb_top;
  localparam int         TEST_H = 20;
  localparam int         TRI_H  = 30;
  localparam logic [5:0] STS    = `ISMO_MUX_STATUS_OFS;
  localparam logic [5:0] MDA    = `ISMO_MUX_MODE_OFS_A;
  localparam logic [5:0] MDB    = `ISMO_MUX_MODE_OFS_B;
  logic                core_clk_i = 1'b0;
  logic                resetn_i = 1'b0;
  logic                mux_mode = 1'b1;
  ismo_pkg::ismo_bus_t bus;
  logic [7:0]          rdata;
  logic                rdata_oe, irq, iface_en, fss, searching, busy, done, all_loc;
  logic [7:0]          ev = 8'h00;
  logic                t_start = 0, t_gen = 0, sfifo = 0, m_cmd = 0, synced = 0;
  logic                c_read = 0, chan_a = 0, w_close = 0, sd_acc = 0, m_req = 0;
  logic                tri_init = 0, chan_b = 0, t_stop = 0;
  logic [7:0]          rv;
  logic                oe;
  int                  miscompares = 0;
  int                  num_checks = 0;
  int                  cycles = 0;
  int                  n;
  logic [1:0]          md [5] = '{2'b00, 2'b10, 2'b01, 2'b11, 2'b11};
  int                  nh [5] = '{512, 5, TEST_H, 19, TRI_H};
  int                  evb [5] = '{7, 5, 4, 2, 1};

  always #5 core_clk_i = ~core_clk_i;

  ismo_host_model host (.core_clk_i(core_clk_i), .bus_o(bus), .rdata_i(rdata),
    .rdata_oe_i(rdata_oe));

  ismo_top #(.HALF_DIV(1), .TEST_HALVES(TEST_H), .TRI_HALVES(TRI_H)) dut (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .mux_mode_i(mux_mode), .bus_i(bus),
    .rdata_o(rdata), .rdata_oe_o(rdata_oe), .timer_start_i(t_start), .timer_gen_i(t_gen),
    .timer_stop_i(t_stop), .timer_expire_i(ev[7]), .sfifo_nonempty_i(sfifo),
    .mon_done_i(ev[5]), .mon_search_cmd_i(m_cmd), .mon_found_i(ev[4]),
    .pcm_synced_i(synced), .mismatch_i(ev[2]), .compare_read_i(c_read),
    .chan_a_enable_i(chan_a), .chan_b_enable_i(chan_b), .swin_open_i(ev[1]),
    .swin_close_i(w_close), .sync_data_access_i(sd_acc), .mem_req_i(m_req),
    .mem_tri_init_i(tri_init), .mem_busy_o(busy), .mem_done_o(done),
    .mem_all_loc_o(all_loc),
    .irq_o(irq), .iface_enable_o(iface_en), .frame_sync_state_o(fss),
    .mon_searching_o(searching));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic pulse(ref logic s);
    @(negedge core_clk_i);
    s = 1'b1;
    @(negedge core_clk_i);
    s = 1'b0;
  endtask

  task automatic ev_pulse(input int b);
    @(negedge core_clk_i);
    ev[b] = 1'b1;
    @(negedge core_clk_i);
    ev[b] = 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask

  task automatic sts(input logic [5:0] a, input logic [7:0] e);
    host.rd(a, rv, oe);
    `CHK(rv, e)
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge core_clk_i);
    @(negedge core_clk_i);
    resetn_i = 1'b1;
    sts(STS, 8'h00);
    `CHK(oe, 1'b1)
    sts(MDA, 8'h00);
    sts(MDB, 8'h00);
    sts(6'h05, 8'h00);
    `CHK(irq, 1'b0)
    $display("test reset done");
    for (int i = 0; i < 5; i++)
    begin
      host.wr(MDA, {md[i], 6'h00});
      sts(MDB, {md[i], 6'h00});
      `CHK(all_loc, ~md[i][1])
      `CHK(iface_en, md[i][0])
      tri_init = (i == 4);
      pulse(m_req);
      n = 0;
      while (busy === 1'b1 && n < 5000)
      begin
        n++;
        @(posedge core_clk_i);
        #1;
      end
      `CHK(n, nh[i])
      `CHK(done, 1'b1)
    end
    tri_init = 1'b0;
    $display("test modes done");
    t_gen = 1'b1;
    pulse(t_start);
    chan_a = 1'b1;
    pulse(m_cmd);
    settle();
    `CHK(searching, 1'b1)
    for (int i = 0; i < 5; i++)
    begin
      ev_pulse(evb[i]);
      settle();
      `CHK(irq, 1'b1)
      sts(STS, 8'(1 << evb[i]));
      sts(STS, 8'h00);
    end
    `CHK(searching, 1'b0)
    ev_pulse(4);
    ev_pulse(2);
    settle();
    sts(STS, 8'h00);
    pulse(c_read);
    pulse(m_cmd);
    ev_pulse(4);
    ev_pulse(2);
    settle();
    sts(STS, 8'h14);
    pulse(w_close);
    settle();
    sts(STS, 8'h01);
    ev_pulse(1);
    pulse(sd_acc);
    pulse(w_close);
    settle();
    sts(STS, 8'h02);
    pulse(t_stop);
    ev_pulse(7);
    settle();
    sts(STS, 8'h00);
    pulse(t_start);
    chan_a = 1'b0;
    ev_pulse(1);
    settle();
    sts(STS, 8'h00);
    chan_b = 1'b1;
    ev_pulse(1);
    settle();
    sts(STS, 8'h02);
    $display("test events done");
    @(negedge core_clk_i);
    synced = 1'b1;
    settle();
    `CHK(fss, 1'b1)
    sts(STS, 8'h08);
    @(negedge core_clk_i);
    synced = 1'b0;
    settle();
    `CHK(fss, 1'b0)
    sts(STS, 8'h08);
    @(negedge core_clk_i);
    sfifo = 1'b1;
    settle();
    `CHK(irq, 1'b1)
    sts(STS, 8'h40);
    sts(STS, 8'h40);
    host.wr(STS, 8'h40);
    settle();
    `CHK(irq, 1'b0)
    sts(STS, 8'h40);
    @(negedge core_clk_i);
    sfifo = 1'b0;
    settle();
    sts(STS, 8'h00);
    host.wr(STS, 8'h80);
    ev_pulse(7);
    settle();
    `CHK(irq, 1'b0)
    sts(STS, 8'h00);
    host.wr(STS, 8'h00);
    settle();
    `CHK(irq, 1'b1)
    host.wr(STS, 8'h00);
    `CHK(irq, 1'b0)
    @(posedge core_clk_i);
    #1;
    `CHK(irq, 1'b1)
    sts(STS, 8'h80);
    $display("test mask done");
    mux_mode = 1'b0;
    sts(`ISMO_DMX_MODE_OFS, 8'hC0);
    ev_pulse(5);
    settle();
    sts(`ISMO_DMX_STATUS_OFS, 8'h20);
    host.wr(`ISMO_DMX_MODE_OFS, 8'hC1);
    sts(`ISMO_DMX_STATUS_OFS, 8'h00);
    $display("test demux done");
    stop_test();
  end
endmodule // tb_top
